// ==== core/fast_pulse_counter_status.sv ====
`timescale 1ns/1ps
`include "fast_tally_defines.svh"
// Functional notes
// R1: accumulator counts external pulses independently of any software activity.
// R2: element is status word, preset word and accumulated word.
// R3: preset and accumulator are two's-complement signed 16-bit values.
// R4: flags retentive; setup clears bits 3-7,14,15 and sets irq allowed.
// R5: up gate flag follows counter enable in all modes.
// R6: down gate flag follows counter enable in bidirectional modes.
// R7: up modes latch top hit flag on reaching high preset.
// R8: up modes set wrap high when preset reached with top hit set.
// R9: bidirectional wrap from max positive to min negative sets wrap high.
// R10: bidirectional wrap from min negative to max positive sets wrap low.
// R11: sync request or enabled counter copies hardware into image accumulator.
// R12: bidirectional at-top flag tracks accumulator at or above high preset.
// R13: bidirectional at-floor flag tracks accumulator at or below low preset.
// R14: overflow or underflow cause flag set clears other cause flags.
// R15: high or low preset cause flag set clears other cause flags.
// R16: queued flag set on interrupt, cleared by service, zero or seed.
// R17: missed flag set when interrupt arrives while one is queued.
// R18: irq allowed set by on, cleared by off; gates interrupts.
// R19: zero command clears hardware and image accumulators.
// R20: seed command loads value into hardware and image accumulators.
// R21: setup applies configuration; counting only while enable is true.
// R22: limits load takes presets and patterns; outputs update at presets. Here it takes only the high preset.
// R23: up modes clear accumulator and reload preset when reached.
// R24: hardware high preset outside 1..32767 rejected with error flag.
// R25: eight modes: up, pulse-direction, up-down, encoder, each optional reset/hold.
// R26: software writes to hardware-owned status flags are ignored. Before setup, at-top and at-floor still take the written value.
// R27: external inputs synchronised, rising edges detected before use.
module fast_pulse_counter_status
   import fast_tally_pkg::*;
(
   input wire logic pclk, // bus clock, 125 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic in_a, // count / up / encoder a
   input wire logic in_b, // direction / down / encoder b
   input wire logic in_z, // external reset / encoder z
   input wire logic in_hold, // hold level
   output logic [15:0] tally_out, // output pattern lines
   output logic irq_pending // queued interrupt level
);
   // ==================================================
   // helpers
   function automatic logic sge(input logic [15:0] x, input logic [15:0] y);
      sge = $signed(x) >= $signed(y);
   endfunction : sge
   function automatic logic preset_ok(input logic [15:0] v);
      preset_ok = $signed(v) >= $signed(16'h0001);
   endfunction : preset_ok
   state_s s;
   state_s n;
   logic up_mode;
   logic rh_mode;
   logic wr;
   logic rd_setup;
   logic [3:0] idx;
   logic addr_ok;
   logic [15:0] cmd;
   logic go_up;
   logic go_down;
   logic top_evt;
   logic floor_evt;
   logic ovf_evt;
   logic unf_evt;
   logic irq_evt;
   pins_s rise;
   logic top_now;
   logic floor_now;
   // ==================================================
   // bus decode
   always_comb begin
      idx = paddr[5:2];
      addr_ok = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) && (idx <= `IDX_INFO);
      wr = psel && penable && pwrite && addr_ok;
      rd_setup = psel && !penable;
      cmd = (wr && idx == `IDX_CMD) ? pwdata[15:0] : 16'h0000;
      up_mode = (s.mode == MODE_UP) || (s.mode == MODE_UP_RH);
      rh_mode = (s.mode == MODE_UP_RH) || (s.mode == MODE_PULSE_DIR_RH) ||
         (s.mode == MODE_UP_DOWN_RH) || (s.mode == MODE_ENCODER_RH);
      rise = s.sync2 & ~s.sync3; // R27
   end
   // ==================================================
   // next state
   always_comb begin
      n = s;
      go_up = 1'b0;
      go_down = 1'b0;
      top_evt = 1'b0;
      floor_evt = 1'b0;
      ovf_evt = 1'b0;
      unf_evt = 1'b0;
      irq_evt = 1'b0;
      top_now = 1'b0;
      floor_now = 1'b0;
      // two flops then an edge stage; stage one feeds only stage two
      n.sync1 = '{a: in_a, b: in_b, z: in_z, hold: in_hold}; // R27
      n.sync2 = s.sync1;
      n.sync3 = s.sync2;
      // register writes; image words only reach hardware on loads
      if (wr && idx == `IDX_STATUS) begin
         // only clearable flags take a written zero; hardware flags kept, except at-top and at-floor before setup
         n.status = s.status & ~(`CLEARABLE_MASK & ~pwdata[15:0]); // R26
         if (pwdata[`B_SYNC_REQ]) begin
            n.img_acc = s.acc; // R11
         end
         if (!s.configured) begin
            n.status[`B_AT_TOP] = pwdata[`B_AT_TOP]; // R12
            n.status[`B_AT_FLOOR] = pwdata[`B_AT_FLOOR];
         end
      end else if (wr && idx == `IDX_PRESET) begin
         n.img_preset = pwdata[15:0]; // R2
      end else if (wr && idx == `IDX_ACCUM) begin
         n.img_acc = pwdata[15:0];
      end else if (wr && idx == `IDX_CTRL) begin
         n.mode = mode_e'(pwdata[3:0]); // R25
         n.enable = pwdata[4];
      end else if (wr && idx == `IDX_LOWPRE) begin
         n.low_preset = pwdata[15:0];
      end else if (wr && idx == `IDX_SEED) begin
         n.seed = pwdata[15:0];
      end else if (wr && idx == `IDX_PATTERN) begin
         n.pattern = pwdata[15:0];
         n.mask = pwdata[31:16];
      end
      // first configuration
      if (cmd[`C_SETUP]) begin
         n.configured = 1'b1; // R21
         n.status = s.status & ~`CFG_CLEAR_MASK; // R4
         n.status[`B_ALLOWED] = 1'b1; // R4
         n.acc = s.img_acc;
         if (preset_ok(s.img_preset)) begin
            n.hw_preset = s.img_preset; // R24
         end else begin
            n.cfg_err = 1'b1; // R24
         end
      end
      if (cmd[`C_LIMITS]) begin
         // only the high preset is loaded, from its image word; pattern applies when written
         if (preset_ok(s.img_preset)) begin
            n.hw_preset = s.img_preset; // R22
         end else begin
            n.cfg_err = 1'b1; // R24
         end
      end
      if (cmd[`C_IRQ_ON]) begin
         n.status[`B_ALLOWED] = 1'b1; // R18
      end
      if (cmd[`C_IRQ_OFF]) begin
         n.status[`B_ALLOWED] = 1'b0; // R18
      end
      if (cmd[`C_SERVICE]) begin
         n.status[`B_QUEUED] = 1'b0; // R16
      end
      // counting, only once configured and while enabled and not held
      if (s.configured && s.enable && !(rh_mode && s.sync2.hold)) begin // R21
         case (s.mode)
            MODE_UP, MODE_UP_RH: go_up = rise.a; // R1
            MODE_PULSE_DIR, MODE_PULSE_DIR_RH: begin
               go_up = rise.a && !s.sync2.b;
               go_down = rise.a && s.sync2.b;
            end
            MODE_UP_DOWN, MODE_UP_DOWN_RH: begin
               go_up = rise.a && !rise.b;
               go_down = rise.b && !rise.a;
            end
            MODE_ENCODER, MODE_ENCODER_RH: begin
               // x1 decode: direction from b at the a edge
               go_up = rise.a && !s.sync2.b;
               go_down = rise.a && s.sync2.b;
            end
            default: begin
               go_up = 1'b0;
               go_down = 1'b0;
            end
         endcase
      end
      if (go_up) begin
         n.acc = s.acc + 16'h0001; // R3
         ovf_evt = !up_mode && (s.acc == `ACC_MAX); // R9
      end else if (go_down) begin
         n.acc = s.acc - 16'h0001;
         unf_evt = (s.acc == `ACC_MIN); // R10
      end
      if (s.configured && rh_mode && rise.z) begin
         n.acc = `ZERO16;
      end
      // zero and seed win over counting in the same cycle
      if (cmd[`C_ZERO] || cmd[`C_SEED]) begin
         n.acc = cmd[`C_SEED] ? s.seed : `ZERO16; // R19 R20
         n.img_acc = n.acc; // R19 R20
         n.status[`B_TOP_HIT] = 1'b0;
         n.status[`B_WRAP_HIGH] = 1'b0;
         n.status[`B_WRAP_LOW] = 1'b0;
         n.status[`B_QUEUED] = 1'b0; // R16
         n.status[`B_MISSED] = 1'b0;
         if (preset_ok(s.img_preset)) begin
            n.hw_preset = s.img_preset;
         end else begin
            n.cfg_err = 1'b1; // R24
         end
      end
      // preset reached and comparator flags
      if (s.configured && up_mode) begin
         if (sge(n.acc, n.hw_preset) && (n.acc != s.acc || n.hw_preset != s.hw_preset)) begin
            top_evt = 1'b1;
            n.acc = `ZERO16; // R23
            n.img_acc = `ZERO16; // R23
            if (preset_ok(s.img_preset)) begin
               n.hw_preset = s.img_preset; // R23
            end
            if (s.status[`B_TOP_HIT]) begin
               n.status[`B_WRAP_HIGH] = 1'b1; // R8
            end else begin
               n.status[`B_TOP_HIT] = 1'b1; // R7
            end
         end
      end else if (s.configured) begin
         top_now = sge(n.acc, n.hw_preset);
         floor_now = sge(s.low_preset, n.acc);
         top_evt = top_now && !s.status[`B_AT_TOP];
         floor_evt = floor_now && !s.status[`B_AT_FLOOR];
         n.status[`B_AT_TOP] = top_now; // R12
         n.status[`B_AT_FLOOR] = floor_now; // R13
         if (ovf_evt) begin
            n.status[`B_WRAP_HIGH] = 1'b1; // R9
         end
         if (unf_evt) begin
            n.status[`B_WRAP_LOW] = 1'b1; // R10
         end
      end
      // up mode overflow is a repeated preset hit
      if (up_mode && top_evt && s.status[`B_TOP_HIT]) begin
         ovf_evt = 1'b1;
      end
      // cause flags: one at a time, overflow ranks first
      if (ovf_evt) begin
         n.status = (n.status & ~`CAUSE_MASK) | (16'h0001 << `B_C_WRAP_HIGH); // R14
      end else if (unf_evt) begin
         n.status = (n.status & ~`CAUSE_MASK) | (16'h0001 << `B_C_WRAP_LOW); // R14
      end else if (top_evt) begin
         n.status = (n.status & ~`CAUSE_MASK) | (16'h0001 << `B_C_TOP_HIT); // R15
      end else if (floor_evt) begin
         n.status = (n.status & ~`CAUSE_MASK) | (16'h0001 << `B_C_FLOOR_HIT); // R15
      end
      // preset hits drive outputs straight from pattern under mask
      if (top_evt || floor_evt) begin
         n.outs = (s.outs & ~s.mask) | (s.pattern & s.mask); // R22
      end
      // interrupt queueing; a set in the clearing cycle wins
      irq_evt = (ovf_evt || unf_evt || top_evt || floor_evt) && s.status[`B_ALLOWED]; // R18
      if (irq_evt) begin
         if (s.status[`B_QUEUED]) begin
            n.status[`B_MISSED] = 1'b1; // R17
         end
         n.status[`B_QUEUED] = 1'b1; // R16
      end
      // gate flags and image refresh while running
      if (s.configured) begin
         n.status[`B_UP_GATE] = s.enable; // R5
         n.status[`B_DOWN_GATE] = s.enable && !up_mode; // R6
         if (s.enable || cmd[`C_SYNC]) begin
            n.img_acc = n.acc; // R11
         end
      end
      if (up_mode) begin
         // reserved in up modes
         n.status[`B_WRAP_LOW] = 1'b0;
         n.status[`B_AT_TOP] = 1'b0;
         n.status[`B_AT_FLOOR] = 1'b0;
      end else begin
         n.status[`B_TOP_HIT] = 1'b0;
      end
      n.status[`B_SYNC_REQ] = 1'b0;
      n.status[0] = 1'b0;
      // read data captured in setup so the access phase needs no wait
      if (rd_setup) begin
         n.pslverr = !addr_ok;
         n.prdata = 32'h0000_0000;
         if (idx == `IDX_STATUS) begin
            n.prdata[15:0] = s.status;
         end else if (idx == `IDX_PRESET) begin
            n.prdata[15:0] = s.img_preset;
         end else if (idx == `IDX_ACCUM) begin
            n.prdata[15:0] = s.img_acc;
         end else if (idx == `IDX_CTRL) begin
            n.prdata[4:0] = {s.enable, s.mode};
         end else if (idx == `IDX_LOWPRE) begin
            n.prdata[15:0] = s.low_preset;
         end else if (idx == `IDX_SEED) begin
            n.prdata[15:0] = s.seed;
         end else if (idx == `IDX_PATTERN) begin
            n.prdata = {s.mask, s.pattern};
         end else if (idx == `IDX_INFO) begin
            n.prdata[15:0] = s.acc;
            n.prdata[17:16] = {s.cfg_err, s.configured};
         end
      end
   end
   // ==================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.status <= `STATUS_RESET;
         s.hw_preset <= `ACC_MAX;
      end else begin
         s <= n;
      end
   end
   // ==================================================
   // outputs
   assign prdata = s.prdata;
   assign pready = 1'b1;
   assign pslverr = s.pslverr && psel && penable;
   assign tally_out = s.outs;
   assign irq_pending = s.status[`B_QUEUED];
   // ==================================================
   // checks
   property p_setup_flags;
      @(posedge pclk) disable iff (!presetn)
      cmd[`C_SETUP] && !irq_evt |=> s.status[`B_ALLOWED] && !s.status[`B_QUEUED];
   endproperty
   a_setup_flags: assert property (p_setup_flags) else $error("setup flags wrong"); // R4
   property p_up_gate;
      @(posedge pclk) disable iff (!presetn)
      s.configured && $stable(s.enable) |=> s.status[`B_UP_GATE] == $past(s.enable);
   endproperty
   a_up_gate: assert property (p_up_gate) else $error("up gate not following enable"); // R5
   property p_wrap_high;
      @(posedge pclk) disable iff (!presetn)
      go_up && !up_mode && s.acc == `ACC_MAX && !cmd[`C_ZERO] && !cmd[`C_SEED]
         |=> s.acc == `ACC_MIN && s.status[`B_WRAP_HIGH] && s.status[`B_C_WRAP_HIGH];
   endproperty
   a_wrap_high: assert property (p_wrap_high) else $error("overflow not flagged"); // R9
   property p_wrap_low;
      @(posedge pclk) disable iff (!presetn)
      go_down && s.acc == `ACC_MIN && !cmd[`C_ZERO] && !cmd[`C_SEED] && !rise.z
         |=> s.acc == `ACC_MAX && s.status[`B_WRAP_LOW];
   endproperty
   a_wrap_low: assert property (p_wrap_low) else $error("underflow not flagged"); // R10
   property p_zero;
      @(posedge pclk) disable iff (!presetn)
      cmd[`C_ZERO] && !cmd[`C_SEED] |=> s.acc == `ZERO16 && s.img_acc == `ZERO16;
   endproperty
   a_zero: assert property (p_zero) else $error("zero command missed"); // R19
   property p_seed;
      @(posedge pclk) disable iff (!presetn)
      cmd[`C_SEED] && !up_mode |=> s.acc == $past(s.seed) && s.img_acc == $past(s.seed);
   endproperty
   a_seed: assert property (p_seed) else $error("seed command missed"); // R20
   property p_missed;
      @(posedge pclk) disable iff (!presetn)
      irq_evt && s.status[`B_QUEUED] |=> s.status[`B_MISSED] && s.status[`B_QUEUED];
   endproperty
   a_missed: assert property (p_missed) else $error("lost interrupt not flagged"); // R17

   property p_one_cause;
      @(posedge pclk) disable iff (!presetn)
      irq_evt |=> $onehot(s.status & `CAUSE_MASK);
   endproperty
   a_one_cause: assert property (p_one_cause) else $error("cause flags not exclusive"); // R14

   property p_no_irq_disallowed;
      @(posedge pclk) disable iff (!presetn)
      !s.status[`B_ALLOWED] && !s.status[`B_QUEUED] && !cmd[`C_IRQ_ON] && !cmd[`C_SETUP]
         |=> !s.status[`B_QUEUED];
   endproperty
   a_no_irq_disallowed: assert property (p_no_irq_disallowed) else $error("irq while off"); // R18

   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      !s.enable && !cmd[`C_ZERO] && !cmd[`C_SEED] && !cmd[`C_SETUP] && !rise.z
         |=> s.acc == $past(s.acc);
   endproperty
   a_stop: assert property (p_stop) else $error("counted while disabled"); // R21

   property p_bad_preset;
      @(posedge pclk) disable iff (!presetn)
      cmd[`C_LIMITS] && !preset_ok(s.img_preset) |=> s.cfg_err;
   endproperty
   a_bad_preset: assert property (p_bad_preset) else $error("bad preset accepted"); // R24

   c_up_hit: cover property (@(posedge pclk) disable iff (!presetn) up_mode && top_evt);
   c_overflow: cover property (@(posedge pclk) disable iff (!presetn) ovf_evt && !up_mode);
   c_missed: cover property (@(posedge pclk) disable iff (!presetn) irq_evt && irq_pending);
   c_floor: cover property (@(posedge pclk) disable iff (!presetn) floor_evt);
endmodule : fast_pulse_counter_status

// ==== pkg/fast_tally_defines.svh ====
`ifndef FAST_TALLY_DEFINES_SVH
`define FAST_TALLY_DEFINES_SVH
// ==================================================
// register indices (byte address is four times the index)
`define IDX_STATUS 4'h0
`define IDX_PRESET 4'h1
`define IDX_ACCUM 4'h2
`define IDX_CMD 4'h3
`define IDX_CTRL 4'h4
`define IDX_LOWPRE 4'h5
`define IDX_SEED 4'h6
`define IDX_PATTERN 4'h7
`define IDX_INFO 4'h8
// ==================================================
// status word bit positions
`define B_UP_GATE 15
`define B_DOWN_GATE 14
`define B_TOP_HIT 13
`define B_WRAP_HIGH 12
`define B_WRAP_LOW 11
`define B_SYNC_REQ 10
`define B_AT_TOP 9
`define B_AT_FLOOR 8
`define B_C_WRAP_HIGH 7
`define B_C_WRAP_LOW 6
`define B_C_TOP_HIT 5
`define B_C_FLOOR_HIT 4
`define B_QUEUED 3
`define B_MISSED 2
`define B_ALLOWED 1
// flags software may clear by writing zero
`define CLEARABLE_MASK 16'h3804
// bits cleared on first configuration: 3..7, 14, 15
`define CFG_CLEAR_MASK 16'hC0F8
// cause flags 4..7
`define CAUSE_MASK 16'h00F0
// ==================================================
// command register bits
`define C_SETUP 0
`define C_ZERO 1
`define C_SEED 2
`define C_IRQ_ON 3
`define C_IRQ_OFF 4
`define C_SYNC 5
`define C_LIMITS 6
`define C_SERVICE 7
// ==================================================
// reset values and limits
`define STATUS_RESET 16'h0000
`define ACC_MAX 16'h7FFF
`define ACC_MIN 16'h8000
`define ZERO16 16'h0000
`endif

// ==== pkg/fast_tally_pkg.sv ====
package fast_tally_pkg;
   // counting modes, codes one to eight
   typedef enum logic [3:0] {
      MODE_OFF = 4'h0,
      MODE_UP = 4'h1,
      MODE_UP_RH = 4'h2,
      MODE_PULSE_DIR = 4'h3,
      MODE_PULSE_DIR_RH = 4'h4,
      MODE_UP_DOWN = 4'h5,
      MODE_UP_DOWN_RH = 4'h6,
      MODE_ENCODER = 4'h7,
      MODE_ENCODER_RH = 4'h8
   } mode_e;

   // external count inputs: a, b, z (reset), hold
   typedef struct packed {
      logic a;
      logic b;
      logic z;
      logic hold;
   } pins_s;

   // whole state of the counter block
   typedef struct packed {
      pins_s sync1;
      pins_s sync2;
      pins_s sync3;
      logic [15:0] acc;
      logic [15:0] hw_preset;
      logic [15:0] img_acc;
      logic [15:0] img_preset;
      logic [15:0] low_preset;
      logic [15:0] seed;
      logic [15:0] pattern;
      logic [15:0] mask;
      logic [15:0] outs;
      logic [15:0] status;
      mode_e mode;
      logic enable;
      logic configured;
      logic cfg_err;
      logic [31:0] prdata;
      logic pslverr;
   } state_s;
endpackage : fast_tally_pkg

// ==== verif/pulse_source.sv ====
`timescale 1ns/1ps
// ==================================================
// far-side model: count pulse and direction lines
module pulse_source (
   input wire logic pclk, // bench clock
   output logic in_a, // count pulse line
   output logic in_b, // direction level, high counts down
   output logic in_z, // external reset pulse line
   output logic in_hold // hold level
);
   // lines idle low from time zero
   initial begin
      in_a = 1'b0;
      in_b = 1'b0;
      in_z = 1'b0;
      in_hold = 1'b0;
   end

   // three cycles high and low, so the input synchroniser never drops an edge
   task pulse(input int n);
      repeat (n) begin
         in_a <= 1'b1;
         repeat (3) @(posedge pclk);
         in_a <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      // let the last count land in the accumulator and its image
      repeat (4) @(posedge pclk);
   endtask : pulse

   // direction is a level, settled well before the next count edge
   task set_dir(input logic down);
      in_b <= down;
      repeat (4) @(posedge pclk);
   endtask : set_dir

   // down pulses on the b line, spaced like the count pulses
   task pulse_b(input int n);
      repeat (n) begin
         in_b <= 1'b1;
         repeat (3) @(posedge pclk);
         in_b <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask : pulse_b

   // one external reset pulse, then time for the clear to settle
   task pulse_z();
      in_z <= 1'b1;
      repeat (3) @(posedge pclk);
      in_z <= 1'b0;
      repeat (7) @(posedge pclk);
   endtask : pulse_z

   // hold is a level; in the reset/hold modes counting stops while it is high
   task set_hold(input logic on);
      in_hold <= on;
      repeat (4) @(posedge pclk);
   endtask : set_hold
endmodule : pulse_source

// ==== verif/test_fast_pulse_counter_status.sv ====
`timescale 1ns/1ps
`include "fast_tally_defines.svh"
// ==================================================
// bench top
module test_fast_pulse_counter_status;
   import fast_tally_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_pending;
   logic in_a, in_b, in_z, in_hold, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [15:0] tally_out;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;

   fast_pulse_counter_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_a(in_a), .in_b(in_b), .in_z(in_z),
      .in_hold(in_hold), .tally_out(tally_out), .irq_pending(irq_pending));
   pulse_source src_u (.pclk(pclk), .in_a(in_a), .in_b(in_b), .in_z(in_z),
      .in_hold(in_hold));

   // ==================================================
   // clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // the whole run needs well under a thousand cycles per scenario
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         test_done();
      end
   end

   // ==================================================
   // shared tasks
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen at an access edge
   task apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {6'h00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [3:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask : wr

   task rd(input logic [3:0] idx, input logic [31:0] exp, input logic [31:0] mask);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rdata & mask, exp);
   endtask : rd

   // ==================================================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // reset state and an unmapped index
      rd(`IDX_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
      rd(`IDX_INFO, 32'h0000_0000, 32'hFFFF_FFFF);
      rd(4'h9, 32'h0000_0000, 32'hFFFF_FFFF);
      chk({31'h0, last_err}, 32'h0000_0001);
      // up mode, preset five
      wr(`IDX_CTRL, 32'h0000_0011);
      wr(`IDX_PRESET, 32'h0000_0005);
      wr(`IDX_CMD, 32'h0000_0001);
      rd(`IDX_STATUS, 32'h0000_8002, 32'hFFFF_FFFF);
      src_u.pulse(4);
      rd(`IDX_ACCUM, 32'h0000_0004, 32'hFFFF_FFFF);
      src_u.pulse(1);
      rd(`IDX_ACCUM, 32'h0000_0000, 32'hFFFF_FFFF);
      rd(`IDX_STATUS, 32'h0000_A02A, 32'hFFFF_FFFF);
      chk({31'h0, irq_pending}, 32'h0000_0001);
      // second hit while one is still queued
      src_u.pulse(5);
      rd(`IDX_STATUS, 32'h0000_B08E, 32'hFFFF_FFFF);
      wr(`IDX_CMD, 32'h0000_0080);
      // the service write lands at the access edge; look once it has settled
      @(negedge pclk);
      chk({31'h0, irq_pending}, 32'h0000_0000);
      // bit clear; hardware-owned flags must survive a write of zero
      wr(`IDX_STATUS, 32'h0000_0000);
      rd(`IDX_STATUS, 32'h0000_8082, 32'hFFFF_FFFF);
      wr(`IDX_SEED, 32'h0000_0003);
      wr(`IDX_CMD, 32'h0000_0004);
      rd(`IDX_ACCUM, 32'h0000_0003, 32'hFFFF_FFFF);
      wr(`IDX_CMD, 32'h0000_0002);
      rd(`IDX_ACCUM, 32'h0000_0000, 32'hFFFF_FFFF);
      // hit with interrupts off: cause set, nothing queued
      wr(`IDX_CMD, 32'h0000_0010);
      src_u.pulse(5);
      rd(`IDX_STATUS, 32'h0000_A020, 32'hFFFF_FFFF);
      wr(`IDX_CMD, 32'h0000_0008);
      rd(`IDX_STATUS, 32'h0000_A022, 32'hFFFF_FFFF);
      // pulse and direction, presets 100 and -100
      wr(`IDX_CTRL, 32'h0000_0013);
      wr(`IDX_PRESET, 32'h0000_0064);
      wr(`IDX_LOWPRE, 32'h0000_FF9C);
      wr(`IDX_CMD, 32'h0000_0001);
      rd(`IDX_STATUS, 32'h0000_C002, 32'h0000_DF02);
      wr(`IDX_SEED, 32'h0000_8000);
      wr(`IDX_CMD, 32'h0000_0004);
      rd(`IDX_STATUS, 32'h0000_C102, 32'h0000_DF02);
      src_u.set_dir(1'b1);
      src_u.pulse(1);
      rd(`IDX_ACCUM, 32'h0000_7FFF, 32'hFFFF_FFFF);
      rd(`IDX_STATUS, 32'h0000_CA02, 32'h0000_DF02);
      src_u.set_dir(1'b0);
      src_u.pulse(1);
      rd(`IDX_STATUS, 32'h0000_D902, 32'h0000_DF02);
      // enable off: gates drop and counting stops
      wr(`IDX_CTRL, 32'h0000_0003);
      rd(`IDX_STATUS, 32'h0000_1902, 32'h0000_DF02);
      src_u.pulse(1);
      rd(`IDX_INFO, 32'h0001_8000, 32'hFFFF_FFFF);
      // out-of-range high preset is refused
      wr(`IDX_PRESET, 32'h0000_0000);
      wr(`IDX_CMD, 32'h0000_0040);
      rd(`IDX_INFO, 32'h0003_8000, 32'hFFFF_FFFF);
      // image refresh by command and by the status sync bit while stopped
      wr(`IDX_ACCUM, 32'h0000_1234);
      rd(`IDX_ACCUM, 32'h0000_1234, 32'hFFFF_FFFF);
      wr(`IDX_CMD, 32'h0000_0020);
      rd(`IDX_ACCUM, 32'h0000_8000, 32'hFFFF_FFFF);
      wr(`IDX_ACCUM, 32'h0000_1234);
      wr(`IDX_STATUS, 32'h0000_3C04);
      rd(`IDX_ACCUM, 32'h0000_8000, 32'hFFFF_FFFF);
      // up and down with reset and hold, preset four, pattern on the hit
      wr(`IDX_CTRL, 32'h0000_0016);
      wr(`IDX_PRESET, 32'h0000_0004);
      wr(`IDX_PATTERN, 32'h00FF_00A5);
      wr(`IDX_CMD, 32'h0000_0003);
      src_u.pulse(3);
      src_u.pulse_b(1);
      rd(`IDX_ACCUM, 32'h0000_0002, 32'hFFFF_FFFF);
      src_u.set_hold(1'b1);
      src_u.pulse(2);
      src_u.set_hold(1'b0);
      rd(`IDX_ACCUM, 32'h0000_0002, 32'hFFFF_FFFF);
      src_u.pulse_z();
      rd(`IDX_ACCUM, 32'h0000_0000, 32'hFFFF_FFFF);
      src_u.pulse(4);
      chk({16'h0000, tally_out}, 32'h0000_00A5);
      rd(`IDX_STATUS, 32'h0000_C202, 32'h0000_DF02);
      test_done();
   end
endmodule : test_fast_pulse_counter_status
